// ===== include/qctp_regs.svh
/*
 * Register offsets, field positions, reset values and masks for the quad
 * counter/timer/PWM block.
 * Assumes a byte-wide register port with a three-bit byte address.
 */
`ifndef QCTP_REGS_SVH
`define QCTP_REGS_SVH

// ***************************************************************
// register offsets
// ***************************************************************
`define QCTP_ADDR_W 3
`define QCTP_OFF_CNT_A 3'h0
`define QCTP_OFF_CNT_B 3'h1
`define QCTP_OFF_CNT_C 3'h2
`define QCTP_OFF_CNT_D 3'h3
`define QCTP_OFF_CLKSEL 3'h4
`define QCTP_OFF_CFG1 3'h5
`define QCTP_OFF_CFG2 3'h6
`define QCTP_OFF_RUN 3'h7

// ***************************************************************
// field positions
// ***************************************************************
`define QCTP_CKSEL_W 2
`define QCTP_DIR_LSB 4
`define QCTP_CHAIN_LSB 2
`define QCTP_PWMEN_LSB 0
`define QCTP_CAPTURE_SOURCE_SEL_MSB 7
`define QCTP_CAPTURE_SOURCE_SEL_LSB 6
`define QCTP_CAPFN_MSB 5
`define QCTP_CAPFN_LSB 4
`define QCTP_RES_W 2
`define QCTP_RES1_LSB 2
`define QCTP_RES0_LSB 0
`define QCTP_RUN_W 4

// ***************************************************************
// reset values and constants
// ***************************************************************
`define QCTP_CLKSEL_RST 8'h00
`define QCTP_CFG1_RST 8'h00
`define QCTP_CFG2_RST 8'h00
`define QCTP_RUN_RST 4'h0
`define QCTP_CNT_RST 8'h00
`define QCTP_CAPTURE_SOURCE_SEL_INT 2'h0
`define QCTP_MASK8 16'h00FF
`define QCTP_MASK10 16'h03FF
`define QCTP_MASK12 16'h0FFF
`define QCTP_MASK14 16'h3FFF
`define QCTP_MASK16 16'hFFFF

`endif

// ===== include/qctp_pkg.sv
/*
 * Types shared by the quad counter/timer/PWM block.
 * Assumes qctp_regs.svh supplies all offsets and field positions.
 */
package qctp_pkg;

	// ***************************************************************
	// capture edge function and clock source codes
	// ***************************************************************
	typedef enum logic [1:0] {
		QCTP_CAP_OFF = 2'b00,
		QCTP_CAP_RISE = 2'b01,
		QCTP_CAP_FALL = 2'b10,
		QCTP_CAP_BOTH = 2'b11
	} qctp_capfn_t;

	typedef enum logic [1:0] {
		QCTP_SRC_PIN = 2'b00,
		QCTP_SRC_INT0 = 2'b01,
		QCTP_SRC_INT1 = 2'b10,
		QCTP_SRC_INT2 = 2'b11
	} qctp_clksrc_t;

	// ***************************************************************
	// per-pair configuration carrier
	// ***************************************************************
	typedef struct packed {
		logic up_hi;
		logic up_lo;
		logic chain;
		logic pwm;
		logic [1:0] res;
	} qctp_pair_cfg_t;

endpackage : qctp_pkg

// ===== design/qctp_sync.sv
/*
 * Two-flop synchroniser with rising-edge pulse, one per input bit.
 * Assumes inputs are slow levels relative to the core clock.
 */
`timescale 1ns/1ps

module qctp_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] din,
	output logic [W-1:0] lvl,
	output logic [W-1:0] rise
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	logic [W-1:0] prev_q;

	// ***************************************************************
	// per-bit stages
	// ***************************************************************
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			// first flop feeds only the second
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					meta_q[i] <= 1'b0;
					sync_q[i] <= 1'b0;
					prev_q[i] <= 1'b0;
				end else begin
					meta_q[i] <= din[i];
					sync_q[i] <= meta_q[i];
					prev_q[i] <= sync_q[i];
				end
			end
			assign rise[i] = sync_q[i] & ~prev_q[i];
			assign lvl[i] = sync_q[i];
		end
	endgenerate

endmodule : qctp_sync

// ===== design/qctp_capture.sv
/*
 * Capture trigger: turns a synchronised level into a one-cycle pulse on the
 * selected edge or edges.
 * Assumes lvl already comes from a synchroniser.
 */
`timescale 1ns/1ps

module qctp_capture (
	input wire logic clk,
	input wire logic rst,
	input wire logic lvl,
	input qctp_pkg::qctp_capfn_t func,
	output logic trig
);

	logic prev_q;
	logic rise;
	logic fall;

	// ***************************************************************
	// edge history
	// ***************************************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= lvl;
		end
	end

	// edge choice from the function field
	always_comb begin
		rise = lvl & ~prev_q;
		fall = ~lvl & prev_q;
		unique case (func)
			qctp_pkg::QCTP_CAP_OFF: trig = 1'b0;
			qctp_pkg::QCTP_CAP_RISE: trig = rise;
			qctp_pkg::QCTP_CAP_FALL: trig = fall;
			qctp_pkg::QCTP_CAP_BOTH: trig = rise | fall;
		endcase
	end

endmodule : qctp_capture

// ===== design/qctp_top.sv
/*
 * Quad 8-bit counter/timer with pairwise chaining, capture on the first
 * pair and two PWM pin drivers, behind a byte register port.
 * Assumes every counter clock source arrives as a slow level that is
 * sampled by the core clock; the port logic does any pin debouncing.
 */
`timescale 1ns/1ps
`include "qctp_regs.svh"

// Overview of operation
// - four 8-bit counters; first/second and third/fourth chain into 16 bits
// - two PWM pins with 8, 10, 12, 14 or 16-bit resolution
// - first pair captures on internal or external signal, one common trigger
// - capture on rising, falling or both edges
// - first pair unchained: counters, PWM+counter, or PWM+captured counter
// - second pair unchained: two counters, or PWM plus counter
// - writing a counter register loads its 8-bit comparison value
// - first pair reads give live count, or captured count in capture mode
// - second pair reads always give live count
// - clock select holds a 2-bit source selector per counter
// - config bits 7..4 set direction per counter, zero is down
// - config bit 3 chains second pair, bit 2 chains first pair
// - config bits 1 and 0 enable the two PWM pins, cleared at reset
// - second config holds capture source and capture function, reset 00
// - second config holds two 2-bit PWM resolution selectors
// - each counter drives its own interrupt line and event line
// - four port pins can clock the counters directly or debounced
// - counters run only when enabled; low enable drives a chained pair
// - when chained, first and third counters hold the low byte
// - counter-mode write also clears (up) or loads (down) the count
module qctp_top (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic [`QCTP_ADDR_W-1:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	input wire logic [3:0] EXT_CLOCK_INPUTS,
	input wire logic [2:0] INT_CLOCKS,
	input wire logic CAP_INT_SIG,
	input wire logic CAP_EXT_SIG,
	output logic [3:0] COUNTER_IRQ,
	output logic [3:0] COUNTER_EVT,
	output logic PWM_PIN_ZERO,
	output logic PWM_PIN_ZERO_OE,
	output logic PWM_PIN_ONE,
	output logic PWM_PIN_ONE_OE
);

	// ***************************************************************
	// declarations
	// ***************************************************************
	logic [7:0] clk_sel_q;
	logic [7:0] cfg1_q;
	logic [7:0] cfg2_q;
	logic [3:0] run_q;
	logic [7:0] cmp_q [4];
	logic [7:0] cnt [4];
	logic [3:0] pend_q;
	logic [3:0] consume;
	logic [3:0] tick;
	logic [3:0] cnt_irq;
	logic [3:0] irq_d;
	logic [3:0] irq_q;
	logic [7:0] cap_a_q;
	logic [7:0] cap_b_q;
	logic [7:0] rdata_q;
	logic [1:0] pwm_lvl;
	logic [1:0] pwm_on;
	logic [1:0] pwm_q;
	logic [1:0] pwm_oe_q;
	logic [3:0] ext_rise;
	logic [2:0] int_rise;
	logic [1:0] cap_lvl;
	logic cap_sig;
	logic cap_trig;
	logic cap_on;
	qctp_pkg::qctp_capfn_t cap_fn;
	qctp_pkg::qctp_pair_cfg_t pcfg [2];

	// one counter step: wraps on match when up, on zero when down
	function automatic logic [16:0] qctp_step(
		input logic [15:0] v,
		input logic [15:0] cmp,
		input logic [15:0] mask,
		input logic up,
		input logic load
	);
		logic [15:0] nx;
		logic wrap;
		nx = 16'h0000;
		wrap = 1'b0;
		if (load) begin
			nx = up ? 16'h0000 : (cmp & mask);
		end else if (up) begin
			if (v == (cmp & mask)) begin
				wrap = 1'b1;
			end else begin
				nx = (v + 16'h0001) & mask;
			end
		end else begin
			if (v == 16'h0000) begin
				nx = cmp & mask;
				wrap = 1'b1;
			end else begin
				nx = v - 16'h0001;
			end
		end
		return {wrap, nx};
	endfunction : qctp_step

	// PWM period mask from the resolution selector
	function automatic logic [15:0] qctp_res_mask(input logic [1:0] res);
		logic [15:0] m;
		m = `QCTP_MASK16;
		unique case (res)
			2'h0: m = `QCTP_MASK10;
			2'h1: m = `QCTP_MASK12;
			2'h2: m = `QCTP_MASK14;
			2'h3: m = `QCTP_MASK16;
		endcase
		return m;
	endfunction : qctp_res_mask

	// ***************************************************************
	// configuration registers
	// ***************************************************************
	// unknown-at-reset fields still get a defined value here
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			clk_sel_q <= `QCTP_CLKSEL_RST;
			cfg1_q <= `QCTP_CFG1_RST;
			cfg2_q <= `QCTP_CFG2_RST;
			run_q <= `QCTP_RUN_RST;
		end else if (WR) begin
			unique case (ADDR)
				`QCTP_OFF_CLKSEL: clk_sel_q <= WDATA;
				`QCTP_OFF_CFG1: cfg1_q <= WDATA;
				`QCTP_OFF_CFG2: cfg2_q <= WDATA;
				`QCTP_OFF_RUN: run_q <= WDATA[`QCTP_RUN_W-1:0];
				default: ;
			endcase
		end
	end

	// comparison values and pending count loads
	// set wins over consume so a write in the tick cycle is not lost
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			for (int k = 0; k < 4; k++) begin
				cmp_q[k] <= `QCTP_CNT_RST;
			end
			pend_q <= 4'h0;
		end else begin
			for (int k = 0; k < 4; k++) begin
				if (WR && ADDR == 3'(k)) begin
					cmp_q[k] <= WDATA;
					pend_q[k] <= 1'b1;
				end else if (consume[k]) begin
					pend_q[k] <= 1'b0;
				end
			end
		end
	end

	// unpack the pair controls
	always_comb begin
		for (int p = 0; p < 2; p++) begin
			pcfg[p].up_lo = cfg1_q[`QCTP_DIR_LSB + 2*p];
			pcfg[p].up_hi = cfg1_q[`QCTP_DIR_LSB + 2*p + 1];
			pcfg[p].chain = cfg1_q[`QCTP_CHAIN_LSB + p];
			pcfg[p].pwm = cfg1_q[`QCTP_PWMEN_LSB + p];
			pcfg[p].res = cfg2_q[`QCTP_RES0_LSB + `QCTP_RES_W*p +:
				`QCTP_RES_W];
		end
	end

	// ***************************************************************
	// clock sources
	// ***************************************************************
	// pins arrive already debounced or raw as the port is set up
	qctp_sync #(
		.W(7)
	) u_clk_sync (
		.clk(CORE_CLK),
		.rst(RST),
		.din({INT_CLOCKS, EXT_CLOCK_INPUTS}),
		.lvl(),
		.rise({int_rise, ext_rise})
	);

	// source picked per counter; a change while running may double-count
	genvar k;
	generate
		for (k = 0; k < 4; k++) begin : g_src
			qctp_pkg::qctp_clksrc_t sel;
			assign sel = qctp_pkg::qctp_clksrc_t'(
				clk_sel_q[k*`QCTP_CKSEL_W +: `QCTP_CKSEL_W]);
			always_comb begin
				unique case (sel)
					qctp_pkg::QCTP_SRC_PIN: tick[k] = ext_rise[k];
					qctp_pkg::QCTP_SRC_INT0: tick[k] = int_rise[0];
					qctp_pkg::QCTP_SRC_INT1: tick[k] = int_rise[1];
					qctp_pkg::QCTP_SRC_INT2: tick[k] = int_rise[2];
				endcase
			end
		end
	endgenerate

	// ***************************************************************
	// counter pairs
	// ***************************************************************
	genvar p;
	generate
		for (p = 0; p < 2; p++) begin : g_pair
			localparam int LO = 2 * p;
			localparam int HI = 2 * p + 1;
			logic [7:0] lo_q;
			logic [7:0] hi_q;
			logic [15:0] mask_lo;
			logic [15:0] v_lo;
			logic [15:0] c_lo;
			logic [16:0] r_lo;
			logic [16:0] r_hi;
			logic t_lo;
			logic t_hi;
			logic ld_lo;
			logic ch;
			logic pw;

			assign ch = pcfg[p].chain;
			assign pw = pcfg[p].pwm;

			// chained value: low counter is the low byte
			always_comb begin
				v_lo = ch ? {hi_q, lo_q} : {8'h00, lo_q};
				c_lo = ch ? {cmp_q[HI], cmp_q[LO]} :
					{8'h00, cmp_q[LO]};
				if (pw && ch) begin
					mask_lo = qctp_res_mask(pcfg[p].res);
				end else if (ch) begin
					mask_lo = `QCTP_MASK16;
				end else begin
					mask_lo = `QCTP_MASK8;
				end
			end

			// low enable runs both halves when chained
			assign t_lo = tick[LO] & run_q[LO];
			assign t_hi = ch ? t_lo : (tick[HI] & run_q[HI]);
			assign ld_lo = ch ? (pend_q[LO] | pend_q[HI]) : pend_q[LO];

			// PWM always counts down and ignores writes
			assign r_lo = pw ? {1'b0, (v_lo - 16'h0001) & mask_lo} :
				qctp_step(v_lo, c_lo, mask_lo, pcfg[p].up_lo,
					ld_lo);
			// companion of a PWM counter counts down
			assign r_hi = qctp_step({8'h00, hi_q}, {8'h00, cmp_q[HI]},
				`QCTP_MASK8, pcfg[p].up_hi & ~pw,
				pend_q[HI]);

			// loads take effect on the first enabled tick only
			assign consume[LO] = t_lo & ~pw;
			assign consume[HI] = ch ? (t_lo & ~pw) : t_hi;

			always_ff @(posedge CORE_CLK or posedge RST) begin
				if (RST) begin
					lo_q <= `QCTP_CNT_RST;
				end else if (t_lo) begin
					lo_q <= r_lo[7:0];
				end
			end

			always_ff @(posedge CORE_CLK or posedge RST) begin
				if (RST) begin
					hi_q <= `QCTP_CNT_RST;
				end else if (ch && t_lo) begin
					hi_q <= r_lo[15:8];
				end else if (!ch && t_hi) begin
					hi_q <= r_hi[7:0];
				end
			end

			// PWM pin high while count sits below the compare value
			assign pwm_lvl[p] = (v_lo & mask_lo) < (c_lo & mask_lo);
			assign pwm_on[p] = pw;
			// no counter interrupt from a PWM counter or a chained high half
			assign cnt_irq[LO] = t_lo & ~pw & r_lo[16];
			assign cnt_irq[HI] = t_hi & ~ch & r_hi[16];
			assign cnt[LO] = lo_q;
			assign cnt[HI] = hi_q;
		end
	endgenerate

	// ***************************************************************
	// capture on the first pair
	// ***************************************************************
	assign cap_fn = qctp_pkg::qctp_capfn_t'(
		cfg2_q[`QCTP_CAPFN_MSB:`QCTP_CAPFN_LSB]);
	assign cap_on = cap_fn != qctp_pkg::QCTP_CAP_OFF;
	// switching the source may fire one stray edge
	assign cap_sig = (cfg2_q[`QCTP_CAPTURE_SOURCE_SEL_MSB:`QCTP_CAPTURE_SOURCE_SEL_LSB] ==
		`QCTP_CAPTURE_SOURCE_SEL_INT) ? cap_lvl[0] : cap_lvl[1];

	qctp_sync #(
		.W(2)
	) u_cap_sync (
		.clk(CORE_CLK),
		.rst(RST),
		.din({CAP_EXT_SIG, CAP_INT_SIG}),
		.lvl(cap_lvl),
		.rise()
	);

	qctp_capture u_capture (
		.clk(CORE_CLK),
		.rst(RST),
		.lvl(cap_sig),
		.func(cap_fn),
		.trig(cap_trig)
	);

	// one trigger latches both counters, chained or not
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			cap_a_q <= `QCTP_CNT_RST;
			cap_b_q <= `QCTP_CNT_RST;
		end else if (cap_trig) begin
			cap_a_q <= cnt[0];
			cap_b_q <= cnt[1];
		end
	end

	// ***************************************************************
	// interrupt and event lines
	// ***************************************************************
	// a PWM first counter in capture mode raises nothing
	always_comb begin
		irq_d = cnt_irq;
		if (cap_on) begin
			irq_d[0] = cap_trig & ~pcfg[0].pwm;
			irq_d[1] = cap_trig;
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			irq_q <= 4'h0;
		end else begin
			irq_q <= irq_d;
		end
	end

	assign COUNTER_IRQ = irq_q;
	assign COUNTER_EVT = irq_q;

	// ***************************************************************
	// PWM pins
	// ***************************************************************
	// enable drops to hand the pin back to the port when PWM is off
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			pwm_q <= 2'h0;
			pwm_oe_q <= 2'h0;
		end else begin
			pwm_q <= pwm_on & pwm_lvl;
			pwm_oe_q <= pwm_on;
		end
	end

	assign PWM_PIN_ZERO = pwm_q[0];
	assign PWM_PIN_ZERO_OE = pwm_oe_q[0];
	assign PWM_PIN_ONE = pwm_q[1];
	assign PWM_PIN_ONE_OE = pwm_oe_q[1];

	// ***************************************************************
	// read port
	// ***************************************************************
	// data stand for one cycle only, zero otherwise
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			rdata_q <= 8'h00;
		end else if (RD) begin
			unique case (ADDR)
				`QCTP_OFF_CNT_A: rdata_q <= cap_on ? cap_a_q : cnt[0];
				`QCTP_OFF_CNT_B: rdata_q <= cap_on ? cap_b_q : cnt[1];
				`QCTP_OFF_CNT_C: rdata_q <= cnt[2];
				`QCTP_OFF_CNT_D: rdata_q <= cnt[3];
				`QCTP_OFF_CLKSEL: rdata_q <= clk_sel_q;
				`QCTP_OFF_CFG1: rdata_q <= cfg1_q;
				`QCTP_OFF_CFG2: rdata_q <= cfg2_q;
				`QCTP_OFF_RUN: rdata_q <= {4'h0, run_q};
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end

	assign RDATA = rdata_q;

endmodule : qctp_top

// ===== test/qctp_monitor.sv
/*
 * Port checker for qctp_top: register port timing, pin enables, lines.
 * Assumes the offsets of qctp_regs.svh and that reset clears every register.
 */
`timescale 1ns/1ps
`include "qctp_regs.svh"

module qctp_monitor (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic [`QCTP_ADDR_W-1:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [7:0] RDATA,
	input wire logic [3:0] COUNTER_IRQ,
	input wire logic [3:0] COUNTER_EVT,
	input wire logic PWM_PIN_ZERO_OE,
	input wire logic PWM_PIN_ONE_OE
);
	// ***************************************************************
	// shadow of the upper four registers
	// ***************************************************************
	logic [7:0] shadow_q [4];
	logic [1:0] en_cd;

	// mirrors writes so reads are judged without looking inside
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			shadow_q <= '{default: 8'h00};
		end else if (WR && ADDR[2]) begin
			shadow_q[ADDR[1:0]] <= (ADDR == `QCTP_OFF_RUN) ?
				{4'h0, WDATA[3:0]} : WDATA;
		end
	end
	assign en_cd = shadow_q[3][3:2];

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);

	sequence s_cfg1_wr;
		WR && ADDR == `QCTP_OFF_CFG1;
	endsequence
	// a write with no second write behind it to muddy the result
	sequence s_cfg1_hold;
		s_cfg1_wr ##1 !(WR && ADDR == `QCTP_OFF_CFG1);
	endsequence

	AST_RD_QUIET: assert property (!$past(RD) |-> RDATA == 8'h00)
		else $error("read data not idle outside read cycle");
	AST_RD_CFG: assert property (RD && ADDR[2] |=>
		RDATA == $past(shadow_q[ADDR[1:0]]))
		else $error("config readback differs from last write");
	AST_RUN_RSVD: assert property (RD && ADDR == `QCTP_OFF_RUN |=>
		RDATA[7:4] == 4'h0)
		else $error("reserved enable bits not zero");
	AST_EVT_COPY: assert property (COUNTER_EVT == COUNTER_IRQ)
		else $error("event lines differ from interrupt lines");
	AST_IRQ_PULSE: assert property (COUNTER_IRQ != 4'h0 |=>
		(COUNTER_IRQ & $past(COUNTER_IRQ)) == 4'h0)
		else $error("interrupt held longer than one cycle");
	AST_OE0_SET: assert property (s_cfg1_hold |=>
		PWM_PIN_ZERO_OE == $past(WDATA[0], 2))
		else $error("pwm0 enable does not follow config");
	AST_OE1_SET: assert property (s_cfg1_hold |=>
		PWM_PIN_ONE_OE == $past(WDATA[1], 2))
		else $error("pwm1 enable does not follow config");
	AST_OE_QUIET: assert property (
		$changed({PWM_PIN_ONE_OE, PWM_PIN_ZERO_OE}) |->
		$past(WR && ADDR == `QCTP_OFF_CFG1) ||
		$past(WR && ADDR == `QCTP_OFF_CFG1, 2))
		else $error("pin enable moved without config write");
	// allows for the tick and the line register behind a disable write
	AST_CD_RUN: assert property (COUNTER_IRQ[3:2] != 2'h0 |->
		(COUNTER_IRQ[3:2] & ~(en_cd | $past(en_cd) | $past(en_cd, 2)))
		== 2'h0)
		else $error("stopped counter raised an interrupt");
endmodule : qctp_monitor

bind qctp_top qctp_monitor u_mon (
	.CORE_CLK(CORE_CLK),
	.RST(RST),
	.ADDR(ADDR),
	.WDATA(WDATA),
	.WR(WR),
	.RD(RD),
	.RDATA(RDATA),
	.COUNTER_IRQ(COUNTER_IRQ),
	.COUNTER_EVT(COUNTER_EVT),
	.PWM_PIN_ZERO_OE(PWM_PIN_ZERO_OE),
	.PWM_PIN_ONE_OE(PWM_PIN_ONE_OE)
);

// ===== test/qctp_cpu_model.sv
/*
 * Processor side of the byte register port: one-cycle write and read.
 * Assumes read data stand only in the cycle after the read strobe.
 */
`timescale 1ns/1ps
`include "qctp_regs.svh"

module qctp_cpu_model (
	input wire logic clk,
	output logic [`QCTP_ADDR_W-1:0] addr,
	output logic [7:0] wdata,
	output logic wr,
	output logic rd,
	input wire logic [7:0] rdata
);
	// idle bus from time zero
	initial begin
		addr = '0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
	end

	task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		wdata <= ~d; // stale data must not be taken again
	endtask : reg_write

	// data sampled mid-cycle, the only cycle where it is valid
	task automatic reg_read(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask : reg_read
endmodule : qctp_cpu_model

// ===== test/tb_top.sv
/*
 * Self-checking bench for qctp_top: readback, counting, chaining, capture.
 * Assumes qctp_cpu_model drives the register port.
 */
`timescale 1ns/1ps
`include "qctp_regs.svh"

module tb_top;
	logic core_clk, rst, wr, rd, cap_int, cap_ext, oe0, oe1, pw1;
	logic [2:0] addr, int_clk;
	logic [7:0] wdata, rdata, v, ca, cc;
	logic [3:0] ext_clk, irq, evt;
	int failures, total_checks, cycles, i, k;
	int irq_cnt [4];
	integer seed;

	qctp_cpu_model cpu (.clk(core_clk), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata));
	qctp_top dut (.CORE_CLK(core_clk), .RST(rst), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.EXT_CLOCK_INPUTS(ext_clk), .INT_CLOCKS(int_clk),
		.CAP_INT_SIG(cap_int), .CAP_EXT_SIG(cap_ext),
		.COUNTER_IRQ(irq), .COUNTER_EVT(evt), .PWM_PIN_ZERO(),
		.PWM_PIN_ZERO_OE(oe0), .PWM_PIN_ONE(pw1), .PWM_PIN_ONE_OE(oe1));

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	// interrupt pulses counted per counter; hang guard
	always @(posedge core_clk) begin
		for (int j = 0; j < 4; j++) if (irq[j] === 1'b1) irq_cnt[j]++;
		cycles++;
		if (cycles == 20000) begin
			failures++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : print_verdict

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
		logic [7:0] d;
		cpu.reg_read(a, d);
		check({8'h00, d}, {8'h00, exp});
	endtask : rd_chk

	task automatic do_reset();
		@(posedge core_clk);
		rst <= 1'b1;
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		irq_cnt = '{default: 0};
	endtask : do_reset

	// one slow clock period on internal source 0 and pin 2 together
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge core_clk);
			int_clk[0] <= 1'b1;
			ext_clk[2] <= 1'b1;
			repeat (3) @(posedge core_clk);
			int_clk[0] <= 1'b0;
			ext_clk[2] <= 1'b0;
			repeat (3) @(posedge core_clk);
		end
	endtask : tick

	task automatic cap(input logic lv);
		@(posedge core_clk);
		cap_int <= lv;
		repeat (6) @(posedge core_clk);
	endtask : cap

	function automatic logic [15:0] exp_up(input int n, input logic [15:0] c);
		return 16'((n - 1) % (c + 1));
	endfunction : exp_up

	function automatic logic [15:0] exp_dn(input int n, input logic [15:0] c);
		return 16'(c - (n - 1) % (c + 1));
	endfunction : exp_dn

	initial begin
		seed = 32'hC65087CC;
		rst = 1'b1;
		int_clk = 3'h0;
		ext_clk = 4'h0;
		cap_int = 1'b0;
		cap_ext = 1'b0;
		irq_cnt = '{default: 0};
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		for (i = 0; i < 8; i++) rd_chk(3'(i), 8'h00);
		// random readback of the upper registers, counters idle
		for (i = 0; i < 8; i++) begin
			v = 8'($random(seed));
			cpu.reg_write(3'(4 + i % 4), v);
			rd_chk(3'(4 + i % 4), i % 4 == 3 ? {4'h0, v[3:0]} : v);
			if (i % 4 == 1) check({14'h0, oe1, oe0}, {14'h0, v[1:0]});
		end
		$display("test readback done");
		do_reset();
		cpu.reg_write(`QCTP_OFF_CLKSEL, 8'h01);
		cpu.reg_write(`QCTP_OFF_CFG1, 8'h10);
		ca = 8'h02 + 8'($random(seed) & 3);
		cc = 8'h02 + 8'($random(seed) & 3);
		cpu.reg_write(`QCTP_OFF_CNT_A, ca);
		cpu.reg_write(`QCTP_OFF_CNT_C, cc);
		cpu.reg_write(`QCTP_OFF_RUN, 8'h05);
		for (k = 1; k <= 8; k++) begin
			tick(1);
			rd_chk(`QCTP_OFF_CNT_A, 8'(exp_up(k, ca)));
			rd_chk(`QCTP_OFF_CNT_C, 8'(exp_dn(k, cc)));
		end
		check(16'(irq_cnt[0]), 16'(7 / (ca + 1)));
		check(16'(irq_cnt[2]), 16'(7 / (cc + 1)));
		cpu.reg_write(`QCTP_OFF_RUN, 8'h04);
		tick(2);
		rd_chk(`QCTP_OFF_CNT_A, 8'(exp_up(8, ca)));
		rd_chk(`QCTP_OFF_CNT_C, 8'(exp_dn(10, cc)));
		$display("test count done");
		do_reset();
		cpu.reg_write(`QCTP_OFF_CLKSEL, 8'h01);
		cpu.reg_write(`QCTP_OFF_CFG1, 8'h14);
		cpu.reg_write(`QCTP_OFF_CNT_B, 8'h01);
		cpu.reg_write(`QCTP_OFF_CNT_A, 8'h02);
		cpu.reg_write(`QCTP_OFF_RUN, 8'h01);
		tick(258);
		rd_chk(`QCTP_OFF_CNT_A, 8'(exp_up(258, 16'h0102)));
		rd_chk(`QCTP_OFF_CNT_B, 8'(exp_up(258, 16'h0102) >> 8));
		check(16'(irq_cnt[0] + irq_cnt[1]), 16'h0000);
		$display("test chain done");
		for (i = 1; i < 4; i++) begin
			do_reset();
			cpu.reg_write(`QCTP_OFF_CLKSEL, 8'h05);
			cpu.reg_write(`QCTP_OFF_CFG1, 8'h30);
			cpu.reg_write(`QCTP_OFF_CFG2, {2'h0, 2'(i), 4'h0});
			cpu.reg_write(`QCTP_OFF_CNT_A, 8'hFF);
			cpu.reg_write(`QCTP_OFF_CNT_B, 8'hFF);
			cpu.reg_write(`QCTP_OFF_RUN, 8'h03);
			tick(5);
			cap(1'b1);
			tick(2);
			cap(1'b0);
			tick(2);
			v = i == 1 ? 8'h04 : 8'h06;
			rd_chk(`QCTP_OFF_CNT_A, v);
			rd_chk(`QCTP_OFF_CNT_B, v);
			check(16'(irq_cnt[0]), i == 3 ? 16'h0002 : 16'h0001);
		end
		$display("test capture done");
		// third counter as 8-bit PWM on pin 2 clock, fourth left plain
		do_reset();
		cpu.reg_write(`QCTP_OFF_CLKSEL, 8'h00);
		cpu.reg_write(`QCTP_OFF_CFG1, 8'h02);
		cpu.reg_write(`QCTP_OFF_CNT_C, 8'hFE);
		cpu.reg_write(`QCTP_OFF_RUN, 8'h04);
		tick(3);
		// pwm counts down from zero and a write does not load it
		rd_chk(`QCTP_OFF_CNT_C, 8'hFD);
		check({15'h0, pw1}, 16'h0001);
		check({15'h0, oe1}, 16'h0001);
		cpu.reg_write(`QCTP_OFF_CNT_C, 8'h10);
		tick(1);
		rd_chk(`QCTP_OFF_CNT_C, 8'hFC);
		check({15'h0, pw1}, 16'h0000);
		$display("test pwm done");
		print_verdict();
	end
endmodule : tb_top
